// >>> hw/serial_paged_flash_port.sv
// Serial paged flash port: frame decode, protection and page modify sequencing
`timescale 1ns/100ps
`include "spf_map.svh"
module serial_paged_flash_port #(
    parameter int PROG_CYCLES = `SPF_PROG_CYC,
    parameter int ERASE_CYCLES = `SPF_ERASE_CYC
) (
    // System clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Protection strap
    input wire logic top_sector_lock_n_i,
    // Status
    output logic busy_flag_o,
    output logic write_enable_latch_o,
    output logic standby_o
);
    logic rst_m_q;
    logic rst_s_q;
    logic cs_m_q;
    logic cs_s_q;
    logic cs_d_q;
    logic lock_m_q;
    logic lock_s_q;
    logic [1:0] prime_q;
    logic tgl_m_q;
    logic tgl_s_q;
    logic seen_q;
    logic armed_q;
    logic cs_rise;
    logic cs_fall;
    logic evt;
    logic ok;
    logic is_mod;
    logic is_erase;
    logic locked;
    logic go;
    logic done;
    logic busy;
    logic wlatch_q;
    spf_pkg::core_state_e state_q;
    logic [7:0] op_q;
    logic [10:0] page_q;
    logic [7:0] idx_q;
    logic [19:0] timer_q;
    logic [18:0] mem_a;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic [7:0] mem_q [0:524287];

    frame_if fr ();

    // Reset release through two stages
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    spi_frame_rx u_link (
        .rst_n_i(rst_s_q),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .mosi_i(mosi_i),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o),
        .fr(fr)
    );

    // Pin and link crossings; the lock resets to locked as the safe side
    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            lock_m_q <= 1'b0;
            lock_s_q <= 1'b0;
            tgl_m_q <= 1'b0;
            tgl_s_q <= 1'b0;
        end else if (ce_i) begin
            cs_m_q <= cs_n_i;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            lock_m_q <= top_sector_lock_n_i;
            lock_s_q <= lock_m_q;
            tgl_m_q <= fr.frame_tgl;
            tgl_s_q <= tgl_m_q;
        end
    end

    assign cs_rise = cs_s_q & ~cs_d_q;
    assign cs_fall = ~cs_s_q & cs_d_q;
    // A frame counts only if the link saw at least one clock edge in it
    assign evt = ce_i & cs_rise & (tgl_s_q != seen_q);

    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            seen_q <= 1'b0;
        end else if (ce_i && cs_rise) begin
            seen_q <= tgl_s_q;
        end
    end

    // A frame already open at reset release is never decoded
    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            armed_q <= 1'b0;
        end else if (ce_i && cs_fall && prime_q == 2'h3) begin
            armed_q <= 1'b1;
        end
    end

    // Select stages hold reset values, not pin samples, until three enabled edges pass
    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            prime_q <= 2'h0;
        end else if (ce_i && prime_q != 2'h3) begin
            prime_q <= prime_q + 2'h1;
        end
    end

    // Frame fields are read only after select rose; the link clock then stands still
    assign ok = evt && armed_q && (fr.bits[2:0] == 3'h0) && busy == 1'b0;
    assign is_mod = (fr.opcode == `SPF_OP_PG_MOD) || (fr.opcode == `SPF_OP_PG_PROG);
    assign is_erase = fr.opcode == `SPF_OP_PG_ERASE;
    assign locked = ~lock_s_q && (fr.addr[18:16] == `SPF_TOP_SECTOR);
    assign go = ok && wlatch_q && !locked
        && ((is_mod && fr.bits >= `SPF_DATA_BITS) || (is_erase && fr.bits == `SPF_A0_BITS));
    assign done = (state_q == spf_pkg::CORE_WAIT) && (timer_q == 20'h00000) && ce_i;
    assign busy = state_q != spf_pkg::CORE_IDLE;

    // Sequencer: one byte per cycle over the page, then the array time
    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            state_q <= spf_pkg::CORE_IDLE;
            op_q <= 8'h00;
            page_q <= 11'h000;
            idx_q <= 8'h00;
            timer_q <= 20'h00000;
        end else if (ce_i) begin
            case (state_q)
                spf_pkg::CORE_IDLE: begin
                    if (go) begin
                        state_q <= spf_pkg::CORE_MOD;
                        op_q <= fr.opcode;
                        page_q <= fr.addr[18:8];
                        idx_q <= 8'h00;
                    end
                end
                spf_pkg::CORE_MOD: begin
                    idx_q <= idx_q + 8'h01;
                    if (idx_q == 8'hFF) begin
                        state_q <= spf_pkg::CORE_WAIT;
                        if (op_q == `SPF_OP_PG_MOD) begin
                            timer_q <= 20'(ERASE_CYCLES + PROG_CYCLES - 1);
                        end else if (op_q == `SPF_OP_PG_ERASE) begin
                            timer_q <= 20'(ERASE_CYCLES - 1);
                        end else begin
                            timer_q <= 20'(PROG_CYCLES - 1);
                        end
                    end
                end
                spf_pkg::CORE_WAIT: begin
                    if (timer_q == 20'h00000) begin
                        state_q <= spf_pkg::CORE_IDLE;
                    end else begin
                        timer_q <= timer_q - 20'h00001;
                    end
                end
                default: begin
                    state_q <= spf_pkg::CORE_IDLE;
                end
            endcase
        end
    end

    // Enable latch; a write enable sent while busy is dropped
    always_ff @(posedge mclk_i or negedge rst_s_q) begin
        if (!rst_s_q) begin
            wlatch_q <= 1'b0;
        end else if (ce_i) begin
            if (done) begin
                wlatch_q <= 1'b0;
            end else if (ok && fr.opcode == `SPF_OP_WR_EN) begin
                wlatch_q <= 1'b1;
            end else if (ok && fr.opcode == `SPF_OP_WR_DIS) begin
                wlatch_q <= 1'b0;
            end
        end
    end

    assign mem_a = {page_q, idx_q};
    assign old_byte = mem_q[mem_a];
    assign fr.rd_idx = idx_q;

    // Merge is computed on the fly, so the link buffer is never written from here
    always_comb begin
        case (op_q)
            `SPF_OP_PG_MOD: new_byte = fr.rd_valid ? fr.rd_data : old_byte;
            `SPF_OP_PG_PROG: new_byte = fr.rd_valid ? (old_byte & fr.rd_data) : old_byte;
            default: new_byte = 8'hFF;
        endcase
    end

    // Array has no reset; contents survive reset except a page cut short mid-cycle
    always_ff @(posedge mclk_i) begin
        if (ce_i && state_q == spf_pkg::CORE_MOD) begin
            mem_q[mem_a] <= new_byte;
        end
    end

    assign fr.busy = busy;
    assign fr.wlatch = wlatch_q;
    assign busy_flag_o = busy;
    assign write_enable_latch_o = wlatch_q;
    assign standby_o = cs_s_q & ~busy;

    chk_write_enable_cmd_sets: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (ok && fr.opcode == `SPF_OP_WR_EN && !done) |=> wlatch_q
    ) else $error("write enable not latched");

    chk_write_disable_cmd_clears: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (ok && fr.opcode == `SPF_OP_WR_DIS) |=> !wlatch_q
    ) else $error("write disable left latch set");

    chk_unarmed_ignored: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (evt && !armed_q && !busy) |=> ($stable(wlatch_q) && state_q == spf_pkg::CORE_IDLE)
    ) else $error("frame decoded before first select fall");

    chk_byte_boundary: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (evt && fr.bits[2:0] != 3'h0 && !busy) |=> ($stable(wlatch_q) && !busy)
    ) else $error("partial byte frame accepted");

    chk_lock_refuses: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (ok && locked && is_mod) |=> (state_q == spf_pkg::CORE_IDLE && $stable(wlatch_q))
    ) else $error("locked page write started");

    chk_cycle_starts: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        go |=> (state_q == spf_pkg::CORE_MOD && idx_q == 8'h00 && busy_flag_o)
    ) else $error("valid frame did not start a cycle");

    chk_page_sweep: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (state_q == spf_pkg::CORE_MOD && idx_q == 8'hFF && ce_i)
            |=> state_q == spf_pkg::CORE_WAIT
    ) else $error("page sweep did not end after last byte");

    chk_program_clears: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (state_q == spf_pkg::CORE_MOD && op_q == `SPF_OP_PG_PROG)
            |-> ((new_byte & ~old_byte) == 8'h00)
    ) else $error("program raised a bit");

    chk_done_clears_wel: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        done |=> (!wlatch_q && state_q == spf_pkg::CORE_IDLE && !busy_flag_o)
    ) else $error("cycle end left latch or busy set");

    chk_standby_state: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (busy || !cs_s_q) |-> !standby_o
    ) else $error("standby while active");

    chk_hiz_deselect: assert property (
        @(posedge mclk_i) disable iff (!rst_s_q)
        (cs_s_q && cs_m_q && cs_n_i) |-> !miso_oe_o
    ) else $error("output driven while deselected");
endmodule

// >>> inc/spf_map.svh
// Constants for the serial paged flash port: opcodes, fields, frame lengths, timing
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

`define SPF_OP_WR_EN 8'h06
`define SPF_OP_WR_DIS 8'h04
`define SPF_OP_RDSR 8'h05
`define SPF_OP_PG_MOD 8'h0A
`define SPF_OP_PG_PROG 8'h02
`define SPF_OP_PG_ERASE 8'hDB

`define SPF_STAT_BUSY_BIT 0
`define SPF_STAT_WLATCH_BIT 1

`define SPF_OP_BITS 12'h008
`define SPF_A2_BITS 12'h010
`define SPF_A1_BITS 12'h018
`define SPF_A0_BITS 12'h020
`define SPF_DATA_BITS 12'h028
`define SPF_HDR_BYTES 9'h005

`define SPF_TOP_SECTOR 3'h7

`define SPF_CLK_PERIOD_NS 25
`define SPF_T_PROG_NS 1000000
`define SPF_T_ERASE_NS 1000000
`define SPF_PROG_CYC ((`SPF_T_PROG_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
`define SPF_ERASE_CYC ((`SPF_T_ERASE_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)

`endif

// >>> inc/spf_pkg.sv
// Types shared by the serial paged flash port
package spf_pkg;
    typedef enum logic [1:0] {
        CORE_IDLE = 2'b00,
        CORE_MOD = 2'b01,
        CORE_WAIT = 2'b10
    } core_state_e;
endpackage

// >>> inc/frame_if.sv
// Frame capture and status between the link side and the core side
`timescale 1ns/100ps
interface frame_if;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [11:0] bits;
    logic frame_tgl;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_valid;
    logic busy;
    logic wlatch;
    modport link (
        output opcode, addr, bits, frame_tgl, rd_data, rd_valid,
        input rd_idx, busy, wlatch
    );
    modport core (
        input opcode, addr, bits, frame_tgl, rd_data, rd_valid,
        output rd_idx, busy, wlatch
    );
endinterface

// >>> hw/spi_frame_rx.sv
// Link side: shifts serial frames in and status out on the serial clock
`timescale 1ns/100ps
`include "spf_map.svh"
module spi_frame_rx (
    // Reset, system copy
    input wire logic rst_n_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Towards the core
    frame_if.link fr
);
    logic fresh_q;
    logic tgl_q;
    logic [11:0] bits_q;
    logic [11:0] nxt;
    logic [6:0] sr_q;
    logic [7:0] byte_in;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic [7:0] wr_idx;
    logic data_done;
    logic [255:0] valid_q;
    logic [7:0] buf_q [0:255];
    logic [1:0] stat_m_q;
    logic [1:0] stat_s_q;
    logic [7:0] stat;
    logic rd_clr;
    logic rd_q;
    logic miso_q;

    // Select high presets this, so the next frame restarts its count
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    assign byte_in = {sr_q, mosi_i};
    assign nxt = fresh_q ? 12'h001 : ((&bits_q) ? bits_q : bits_q + 12'h001);
    assign data_done = (nxt >= `SPF_DATA_BITS) && (nxt[2:0] == 3'h0);
    assign wr_idx = addr_q[7:0] + 8'(nxt[11:3] - `SPF_HDR_BYTES);

    // Capture on the rising edge; works for either idle level
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_q <= 1'b0;
            bits_q <= 12'h000;
            sr_q <= 7'h00;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (!cs_n_i) begin
            // Idle level changes while deselected must not look like a frame
            tgl_q <= tgl_q ^ fresh_q;
            bits_q <= nxt;
            sr_q <= byte_in[6:0];
            case (nxt)
                `SPF_OP_BITS: op_q <= byte_in;
                `SPF_A2_BITS: addr_q[23:16] <= byte_in;
                `SPF_A1_BITS: addr_q[15:8] <= byte_in;
                `SPF_A0_BITS: addr_q[7:0] <= byte_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_q <= '0;
        end else if (fresh_q && !cs_n_i) begin
            valid_q <= '0;
        end else if (data_done) begin
            valid_q[wr_idx] <= 1'b1;
        end
    end

    always_ff @(posedge sclk_i) begin
        if (data_done) begin
            buf_q[wr_idx] <= byte_in;
        end
    end

    // Status crosses as two levels; the first of each pair feeds only the second
    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_m_q <= 2'b00;
            stat_s_q <= 2'b00;
        end else begin
            stat_m_q <= {fr.wlatch, fr.busy};
            stat_s_q <= stat_m_q;
        end
    end

    assign stat = {6'h00, stat_s_q};
    assign rd_clr = cs_n_i | ~rst_n_i;

    always_ff @(negedge sclk_i or posedge rd_clr) begin
        if (rd_clr) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= !fresh_q && (op_q == `SPF_OP_RDSR) && (bits_q >= `SPF_OP_BITS);
        end
    end

    always_ff @(negedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= stat[3'h7 - bits_q[2:0]];
        end
    end

    assign miso_o = miso_q;
    assign miso_oe_o = rd_q & ~cs_n_i & rst_n_i;

    assign fr.opcode = op_q;
    assign fr.addr = addr_q;
    assign fr.bits = bits_q;
    assign fr.frame_tgl = tgl_q;
    assign fr.rd_data = buf_q[fr.rd_idx];
    assign fr.rd_valid = valid_q[fr.rd_idx];
endmodule

// >>> verification/spi_master_model.sv
// Serial bus master model driving the link pins of the flash port
`timescale 1ns/100ps
module spi_master_model (
    // Serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    logic cpol_q = 1'b0;
    // Select starts low so the first frame after reset has no falling edge
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        mosi_o = 1'b0;
    end
    // Clock stands at its idle level outside frames
    task automatic set_mode(input logic cpol);
        cpol_q = cpol;
        sclk_o = cpol;
        #200;
    endtask
    // Header bits from the top of hdr, then nrand random bits, MSB first
    // Select falls before and rises after exactly nhdr + nrand pulses
    // Bits change on the low phase, output is taken on the rising edge
    task automatic frame(input logic [63:0] hdr, input int nhdr, input int nrand,
            output logic [63:0] rx);
        logic b;
        rx = 64'h0;
        cs_n_o = 1'b0;
        #32;
        for (int i = 0; i < nhdr + nrand; i++) begin
            b = (i < nhdr) ? hdr[63 - i] : 1'($urandom);
            if (cpol_q || i > 0) sclk_o = 1'b0;
            mosi_o = b;
            #32;
            sclk_o = 1'b1;
            rx = {rx[62:0], miso_i};
            #32;
        end
        sclk_o = cpol_q;
        // Released line shows the inverse so a stale bit cannot pass
        mosi_o = ~mosi_o;
        #32;
        cs_n_o = 1'b1;
        #200;
    endtask
endmodule

// >>> verification/serial_paged_flash_port_bench.sv
// Self-checking bench for the serial paged flash port
`timescale 1ns/100ps
`include "spf_map.svh"
module serial_paged_flash_port_bench;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0; // Low from power-on until released
    logic ce_i = 1'b1;
    logic lock_n = 1'b1;
    logic sclk, cs_n, mosi, miso, miso_oe, busy, wlatch, standby;
    wire miso_w;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [63:0] rx;
    logic [7:0] ops [3] = '{`SPF_OP_PG_MOD, `SPF_OP_PG_PROG, `SPF_OP_PG_ERASE};
    // Nothing pulls the data line, so an undriven bit reads as z and fails
    assign miso_w = miso_oe ? miso : 1'bz;
    serial_paged_flash_port #(.PROG_CYCLES(8), .ERASE_CYCLES(8)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .top_sector_lock_n_i(lock_n),
        .busy_flag_o(busy), .write_enable_latch_o(wlatch), .standby_o(standby)
    );
    spi_master_model i_master (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: run too long", $time);
            end_sim();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    function automatic logic [7:0] status_of(input logic b, input logic w);
        return {6'h00, w, b};
    endfunction
    task automatic settle();
        repeat (10) @(posedge mclk_i);
    endtask
    task automatic flags(input logic b, input logic w, input string m);
        check({6'h00, wlatch, busy}, status_of(b, w), m);
    endtask
    task automatic send(input logic [7:0] op, input logic [23:0] a, input int nh, input int nd);
        i_master.frame({op, a, 32'h0}, nh, nd * 8, rx);
    endtask
    task automatic rdsr(input logic b, input logic w);
        i_master.frame({`SPF_OP_RDSR, 56'h0}, 8, 8, rx);
        check(rx[7:0], status_of(b, w), "status byte");
        check({7'h00, miso_oe}, 8'h00, "output after select high");
    endtask
    task automatic do_reset();
        @(posedge mclk_i) rst_n_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        flags(1'b0, 1'b0, "flags in reset");
        check({6'h00, standby, miso_oe}, 8'h02, "pins in reset");
        @(posedge mclk_i) rst_n_i <= 1'b1;
        settle();
    endtask
    task automatic modify(input logic [7:0] op, input logic [23:0] a, input int nd,
            input logic ok);
        send(`SPF_OP_WR_EN, 24'h0, 8, 0);
        send(op, a, 32, nd);
        settle();
        flags(ok, 1'b1, "cycle start");
        if (ok) begin
            check({7'h00, standby}, 8'h00, "standby while busy");
            rdsr(1'b1, 1'b1);
            // Frames other than status are refused while busy
            send(`SPF_OP_WR_DIS, 24'h0, 8, 0);
            rdsr(1'b1, 1'b1);
            for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge mclk_i);
            flags(1'b0, 1'b0, "cycle end");
            settle();
            check({7'h00, standby}, 8'h01, "standby when idle");
        end
    endtask
    initial begin
        void'($urandom(41));
        do_reset();
        send(`SPF_OP_WR_EN, 24'h0, 8, 0);
        settle();
        flags(1'b0, 1'b0, "frame open at release");
        $display("test select edge done");
        for (int m = 0; m < 2; m++) begin
            i_master.set_mode(m[0]);
            send(`SPF_OP_WR_EN, 24'h0, 8, 0);
            rdsr(1'b0, 1'b1);
            send(`SPF_OP_WR_DIS, 24'h0, 8, 0);
            rdsr(1'b0, 1'b0);
        end
        $display("test modes done");
        send(`SPF_OP_WR_EN, 24'h0, 7, 0);
        rdsr(1'b0, 1'b0);
        send(`SPF_OP_WR_EN, 24'h0, 9, 0);
        rdsr(1'b0, 1'b0);
        send(`SPF_OP_WR_EN, 24'h0, 8, 0);
        send(`SPF_OP_PG_MOD, 24'h010000, 44, 0);
        settle();
        flags(1'b0, 1'b1, "partial byte");
        send(`SPF_OP_PG_MOD, 24'h010000, 32, 0);
        settle();
        flags(1'b0, 1'b1, "no data byte");
        send(`SPF_OP_PG_ERASE, 24'h010000, 40, 0);
        settle();
        flags(1'b0, 1'b1, "erase too long");
        send(`SPF_OP_WR_DIS, 24'h0, 8, 0);
        send(`SPF_OP_PG_PROG, 24'h012300, 32, 4);
        settle();
        flags(1'b0, 1'b0, "no enable");
        $display("test refusals done");
        @(posedge mclk_i) lock_n <= 1'b0;
        settle();
        for (int k = 0; k < 3; k++) begin
            modify(ops[k], {8'h07, 16'($urandom)}, (k == 2) ? 0 : 1, 1'b0);
        end
        modify(`SPF_OP_PG_MOD, {8'h06, 16'($urandom)}, 1 + $urandom % 256, 1'b1);
        $display("test lock low done");
        @(posedge mclk_i) lock_n <= 1'b1;
        settle();
        for (int k = 0; k < 3; k++) begin
            modify(ops[k], {8'h07, 16'($urandom)}, (k == 2) ? 0 : 1 + $urandom % 256, 1'b1);
        end
        modify(`SPF_OP_PG_MOD, 24'h0300FF, 256, 1'b1);
        modify(`SPF_OP_PG_MOD, 24'h034010, 260, 1'b1);
        $display("test lock high done");
        send(`SPF_OP_WR_EN, 24'h0, 8, 0);
        send(`SPF_OP_PG_MOD, 24'h020000, 32, 8);
        settle();
        flags(1'b1, 1'b1, "cycle before reset");
        do_reset();
        rdsr(1'b0, 1'b0);
        $display("test reset mid cycle done");
        end_sim();
    end
endmodule
